// ===== halt_pkg.sv
// Function
// RULE1: halt instruction enters halt from either cpu clock source
// RULE2: cpu clock is gated off while halted, every clock source
// RULE3: port output latch keeps its value throughout halt
// RULE4: high-speed halt keeps peripherals running; low-speed halt gives no guarantee
// RULE5: low-speed halt: timer a counts only on its external event input
// RULE6: low-speed halt: timer b counts only on low-speed clock divided by 128
// RULE7: low-speed halt: serial port works only when clocked by running timer a
// RULE8: watchdog runs in halt only when low-speed oscillator is non-stoppable
// RULE9: unmasked request releases halt; vectored service if enabled, else next instruction
// RULE10: release into vectored servicing waits 8 or 9 cpu clocks
// RULE11: release into next instruction waits 2 or 3 cpu clocks
// RULE12: external reset releases halt, resets, restarts from reset vector
// RULE13: software may switch clock at once when x1 takes an external clock
// RULE14: software waits 300 us and 50 us before selecting the internal oscillator
// RULE15: software times that wait with 85 no-operation instructions
// RULE16: masked requests leave the device halted
// RULE17: a request pending at the halt instruction releases at once with normal wait
package halt_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] PORT_OFFSET = 8'h08;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // release wait counts, in cpu clocks
    // ------------------------------------------------------------
    localparam logic [3:0] WAIT_VECTORED = 4'h8;
    localparam logic [3:0] WAIT_SEQUENTIAL = 4'h2;

    // control word: bit 0 is clk_src_low
    typedef struct packed {
        logic serial_clk_timer_a; // serial_port_zero clocked by timer_a_output
        logic timer_b_div128;     // timer b counts low_speed_osc_frequency / 128
        logic timer_a_event;      // timer a counts timer_a_event_input
        logic osc_stoppable;      // low-speed oscillator may be stopped by software
        logic clk_src_low;        // cpu runs from the low-speed oscillator
    } ctrl_t;

    // peripheral run/guarantee flags
    typedef struct packed {
        logic wdt;
        logic muldiv;
        logic serial;
        logic adc;
        logic rt_out;
        logic timer_b;
        logic timer_a;
        logic timer16;
        logic inv_timer;
    } periph_run_t;

    // status word, low bit is halted
    typedef struct packed {
        periph_run_t run;
        logic release_vectored;
        logic in_reset;
        logic cpu_clk_en;
        logic halted;
    } status_t;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAIT, ST_RESET} state_t;

    // true when the offset names a mapped register
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        reg_hit = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET) || (addr == PORT_OFFSET);
    endfunction

endpackage

// ===== periph_gate.sv
`timescale 1ns/100ps
`default_nettype none
module periph_gate (
    input wire logic halted,
    input wire halt_pkg::ctrl_t ctrl,
    output halt_pkg::periph_run_t run
);
    logic low_halt;
    assign low_halt = halted & ctrl.clk_src_low;

    // ------------------------------------------------------------
    // guarantee map during halt
    // ------------------------------------------------------------
    // RULE4: high-speed halt keeps these
    assign run.inv_timer = ~low_halt;
    assign run.timer16 = ~low_halt;
    assign run.rt_out = ~low_halt;
    assign run.adc = ~low_halt;
    assign run.muldiv = ~low_halt;
    // RULE5: timer a event clock
    assign run.timer_a = ~low_halt | ctrl.timer_a_event;
    // RULE6: timer b divided clock
    assign run.timer_b = ~low_halt | ctrl.timer_b_div128;
    // RULE7: serial clocked by timer a, only while timer a itself runs
    assign run.serial = ~low_halt | (ctrl.serial_clk_timer_a & run.timer_a);
    // RULE8: watchdog follows the oscillator option
    assign run.wdt = ~(halted & ctrl.osc_stoppable);
endmodule // periph_gate
`default_nettype wire

// ===== axil_port.sv
`timescale 1ns/100ps
`default_nettype none
module axil_port (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [halt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output var logic awready,
    input wire logic wvalid,
    output var logic wready,
    output var logic [1:0] bresp,
    output var logic bvalid,
    input wire logic bready,
    input wire logic [halt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output var logic arready,
    output var logic [31:0] rdata,
    output var logic [1:0] rresp,
    output var logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rd_data,
    output logic wr_en,
    output logic [halt_pkg::ADDR_W-1:0] wr_addr,
    output logic [halt_pkg::ADDR_W-1:0] rd_addr
);
    logic have_aw_ff, have_w_ff, rd_pend_ff;

    // write fires once both halves are held and no response is open
    assign wr_en = have_aw_ff & have_w_ff & ~bvalid;

    // ------------------------------------------------------------
    // write channels, address and data in either order
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            awready <= 1'b1;
            wready <= 1'b1;
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            bvalid <= 1'b0;
            bresp <= halt_pkg::RESP_OKAY;
            wr_addr <= '0;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                have_aw_ff <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                have_w_ff <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_en) begin
                bvalid <= 1'b1;
                bresp <= halt_pkg::reg_hit(wr_addr) ? halt_pkg::RESP_OKAY : halt_pkg::RESP_SLVERR;
                have_aw_ff <= 1'b0;
                have_w_ff <= 1'b0;
            end
            // readies stay low until the response is taken: one write at a time
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel, data one cycle after the address is taken
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            arready <= 1'b1;
            rd_pend_ff <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= halt_pkg::RESP_OKAY;
            rd_addr <= '0;
        end else begin
            if (arvalid && arready) begin
                rd_addr <= araddr;
                rd_pend_ff <= 1'b1;
                arready <= 1'b0;
            end
            if (rd_pend_ff) begin
                rd_pend_ff <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= halt_pkg::reg_hit(rd_addr) ? halt_pkg::RESP_OKAY : halt_pkg::RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // axil_port
`default_nettype wire

// ===== halt_standby_control.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module halt_standby_control #(
    parameter int IRQ_N = 8,
    parameter int PORT_W = 8
) (
    input wire logic mclk,
    input wire logic reset,
    // register bus
    input wire logic [halt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output var logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output var logic wready,
    output var logic [1:0] bresp,
    output var logic bvalid,
    input wire logic bready,
    input wire logic [halt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output var logic arready,
    output var logic [31:0] rdata,
    output var logic [1:0] rresp,
    output var logic rvalid,
    input wire logic rready,
    // cpu core
    input wire logic halt_exec,
    output var logic cpu_clk_en_ff,
    output var logic cpu_reset_ff,
    output var logic vector_go_ff,
    output var logic resume_go_ff,
    output var logic reset_vector_go_ff,
    // interrupt controller and reset pin
    input wire logic [IRQ_N-1:0] irq_flag,
    input wire logic [IRQ_N-1:0] irq_mask,
    input wire logic irq_vectored,
    input wire logic ext_reset_n,
    // ports and peripherals
    output var logic [PORT_W-1:0] port_out_ff,
    output var halt_pkg::periph_run_t periph_run_ff
);
    halt_pkg::state_t state_ff, nxt_state;
    halt_pkg::ctrl_t ctrl_ff;
    halt_pkg::status_t status;
    halt_pkg::periph_run_t nxt_run;
    logic [3:0] wait_cnt_ff;
    logic vec_sel_ff, nxt_vec_sel;
    logic unmasked, wait_done, wr_en, halted_next;
    logic [halt_pkg::ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] rd_data;
    logic [31:0] wdata_ff;
    logic wstrb_lane0_ff;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    axil_port u_bus (
        .mclk(mclk),
        .reset(reset),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .rd_addr(rd_addr)
    );

    // ------------------------------------------------------------
    // release sources
    // ------------------------------------------------------------
    // RULE16: masked requests never count
    assign unmasked = |(irq_flag & ~irq_mask);
    assign wait_done = (state_ff == halt_pkg::ST_WAIT) && (wait_cnt_ff == 4'h1);

    // next state; the reset pin beats every other source
    always_comb begin
        nxt_state = state_ff;
        nxt_vec_sel = vec_sel_ff;
        if (!ext_reset_n) begin
            // RULE12: pin releases halt into reset
            nxt_state = halt_pkg::ST_RESET;
        end else begin
            unique case (state_ff)
                halt_pkg::ST_RUN: begin
                    if (halt_exec) begin
                        // RULE1: entry from either clock source
                        // RULE17: pending request releases at once
                        nxt_state = unmasked ? halt_pkg::ST_WAIT : halt_pkg::ST_HALT;
                        nxt_vec_sel = irq_vectored;
                    end
                end
                halt_pkg::ST_HALT: begin
                    // RULE9: unmasked request releases
                    if (unmasked) begin
                        nxt_state = halt_pkg::ST_WAIT;
                        nxt_vec_sel = irq_vectored;
                    end
                end
                halt_pkg::ST_WAIT: begin
                    if (wait_done) begin
                        nxt_state = halt_pkg::ST_RUN;
                    end
                end
                halt_pkg::ST_RESET: begin
                    nxt_state = halt_pkg::ST_RUN;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= halt_pkg::ST_RUN;
            vec_sel_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            vec_sel_ff <= nxt_vec_sel;
        end
    end

    // ------------------------------------------------------------
    // release wait counter
    // ------------------------------------------------------------
    // the lower of each documented pair is used: the shorter wait is always legal
    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_cnt_ff <= 4'h0;
        end else if (nxt_state == halt_pkg::ST_WAIT && state_ff != halt_pkg::ST_WAIT) begin
            // RULE10: vectored wait
            // RULE11: sequential wait
            wait_cnt_ff <= nxt_vec_sel ? halt_pkg::WAIT_VECTORED : halt_pkg::WAIT_SEQUENTIAL;
        end else if (state_ff == halt_pkg::ST_WAIT) begin
            wait_cnt_ff <= wait_cnt_ff - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // cpu side outputs
    // ------------------------------------------------------------
    assign halted_next = (nxt_state == halt_pkg::ST_HALT) || (nxt_state == halt_pkg::ST_WAIT);

    // RULE2: clock gated in halt and through the release wait
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_clk_en_ff <= 1'b1;
        end else begin
            cpu_clk_en_ff <= ~halted_next;
        end
    end

    // RULE12: reset held while the pin is low, then vector restart
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_reset_ff <= 1'b0;
            reset_vector_go_ff <= 1'b0;
        end else begin
            cpu_reset_ff <= (nxt_state == halt_pkg::ST_RESET);
            reset_vector_go_ff <= (state_ff == halt_pkg::ST_RESET) && ext_reset_n;
        end
    end

    // RULE9: one pulse picks servicing or next instruction
    always_ff @(posedge mclk) begin
        if (reset) begin
            vector_go_ff <= 1'b0;
            resume_go_ff <= 1'b0;
        end else begin
            vector_go_ff <= wait_done && ext_reset_n && vec_sel_ff;
            resume_go_ff <= wait_done && ext_reset_n && !vec_sel_ff;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // write data is held from its own handshake: the master may drop it before the address arrives
    always_ff @(posedge mclk) begin
        if (reset) begin
            wdata_ff <= 32'h0000_0000;
            wstrb_lane0_ff <= 1'b0;
        end else if (wvalid && wready) begin
            wdata_ff <= wdata;
            wstrb_lane0_ff <= wstrb[0];
        end
    end

    // control bits steer the peripheral guarantee map
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_ff <= halt_pkg::CTRL_RESET;
        end else if (wr_en && wr_addr == halt_pkg::CTRL_OFFSET && wstrb_lane0_ff) begin
            ctrl_ff <= wdata_ff[$bits(halt_pkg::ctrl_t)-1:0];
        end
    end

    // RULE3: latch frozen while halted, writes then dropped
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_out_ff <= PORT_W'(halt_pkg::PORT_RESET);
        end else if (wr_en && wr_addr == halt_pkg::PORT_OFFSET && wstrb_lane0_ff
                     && state_ff == halt_pkg::ST_RUN) begin
            port_out_ff <= wdata_ff[PORT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // peripheral guarantee map
    // ------------------------------------------------------------
    periph_gate u_gate (
        .halted(halted_next),
        .ctrl(ctrl_ff),
        .run(nxt_run)
    );

    // RULE4: flags registered with the state they belong to
    always_ff @(posedge mclk) begin
        if (reset) begin
            periph_run_ff <= '1;
        end else begin
            periph_run_ff <= nxt_run;
        end
    end

    // read mux; unmapped offsets read zero with an error response
    assign status = '{run: periph_run_ff, release_vectored: vec_sel_ff,
                      in_reset: cpu_reset_ff, cpu_clk_en: cpu_clk_en_ff,
                      halted: (state_ff != halt_pkg::ST_RUN) && (state_ff != halt_pkg::ST_RESET)};
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr == halt_pkg::CTRL_OFFSET) begin
            rd_data[$bits(halt_pkg::ctrl_t)-1:0] = ctrl_ff;
        end else if (rd_addr == halt_pkg::STATUS_OFFSET) begin
            rd_data[$bits(halt_pkg::status_t)-1:0] = status;
        end else if (rd_addr == halt_pkg::PORT_OFFSET) begin
            rd_data[PORT_W-1:0] = port_out_ff;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_halt_entry: assert property (@(posedge mclk) disable iff (reset) // RULE1
        (state_ff == halt_pkg::ST_RUN && halt_exec && !unmasked && ext_reset_n)
        |=> (state_ff == halt_pkg::ST_HALT) && !cpu_clk_en_ff)
        else $error("halt instruction did not enter halt");

    a_clock_gated: assert property (@(posedge mclk) disable iff (reset) // RULE2
        (state_ff == halt_pkg::ST_HALT) |-> !cpu_clk_en_ff && !vector_go_ff && !resume_go_ff)
        else $error("cpu clock running in halt");

    a_port_frozen: assert property (@(posedge mclk) disable iff (reset) // RULE3
        (state_ff == halt_pkg::ST_HALT) |=> $stable(port_out_ff))
        else $error("port latch changed in halt");

    a_fast_halt_run: assert property (@(posedge mclk) disable iff (reset) // RULE4
        (state_ff == halt_pkg::ST_HALT && !ctrl_ff.clk_src_low)
        |-> periph_run_ff.adc && periph_run_ff.timer16 && periph_run_ff.serial && periph_run_ff.muldiv)
        else $error("peripheral dropped in high-speed halt");

    a_timer_a_gate: assert property (@(posedge mclk) disable iff (reset) // RULE5
        (state_ff == halt_pkg::ST_HALT && ctrl_ff.clk_src_low && $stable(ctrl_ff))
        |-> periph_run_ff.timer_a == ctrl_ff.timer_a_event)
        else $error("timer a guarantee wrong");

    a_wdt_option: assert property (@(posedge mclk) disable iff (reset) // RULE8
        (state_ff == halt_pkg::ST_HALT && $stable(ctrl_ff))
        |-> periph_run_ff.wdt == !ctrl_ff.osc_stoppable)
        else $error("watchdog run flag wrong in halt");

    a_vector_wait: assert property (@(posedge mclk) disable iff (reset) // RULE10
        (state_ff == halt_pkg::ST_HALT && unmasked && irq_vectored && ext_reset_n)
        |=> (!cpu_clk_en_ff && ext_reset_n) [*8] ##1 (vector_go_ff && cpu_clk_en_ff))
        else $error("vectored release wait not 8 clocks");

    a_resume_wait: assert property (@(posedge mclk) disable iff (reset) // RULE11
        (state_ff == halt_pkg::ST_HALT && unmasked && !irq_vectored && ext_reset_n)
        |=> (!cpu_clk_en_ff && ext_reset_n) [*2] ##1 (resume_go_ff && !vector_go_ff))
        else $error("sequential release wait not 2 clocks");

    a_pin_reset: assert property (@(posedge mclk) disable iff (reset) // RULE12
        (!ext_reset_n ##1 ext_reset_n) |=> reset_vector_go_ff && !cpu_reset_ff)
        else $error("no reset vector after pin release");

    a_masked_hold: assert property (@(posedge mclk) disable iff (reset) // RULE16
        (state_ff == halt_pkg::ST_HALT && !unmasked && ext_reset_n) |=> state_ff == halt_pkg::ST_HALT)
        else $error("masked request left halt");

    a_pending_halt: assert property (@(posedge mclk) disable iff (reset) // RULE17
        (state_ff == halt_pkg::ST_RUN && halt_exec && unmasked && ext_reset_n)
        |=> state_ff == halt_pkg::ST_WAIT)
        else $error("pending request did not release at once");
endmodule // halt_standby_control
`default_nettype wire

// ===== irq_model.sv
`timescale 1ns/100ps
`default_nettype none
// stand-in for the interrupt controller and the reset pin; the other lines
// always pend but stay masked, so a design that ignores the mask releases early
module irq_model #(
    parameter int IRQ_N = 8,
    parameter int LINE = 3
) (
    input wire logic req_on,
    input wire logic masked,
    input wire logic vect,
    input wire logic pin_low,
    output logic [IRQ_N-1:0] irq_flag,
    output logic [IRQ_N-1:0] irq_mask,
    output logic irq_vectored,
    output logic ext_reset_n
);
    logic [IRQ_N-1:0] one_hot;
    assign one_hot = IRQ_N'(1) << LINE;
    // pending lines count only with their mask bit clear
    assign irq_flag = req_on ? '1 : ~one_hot;
    assign irq_mask = masked ? '1 : ~one_hot;
    // acknowledge decision taken straight from the vect input
    assign irq_vectored = vect;
    assign ext_reset_n = ~pin_low;
endmodule // irq_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, halt_exec, req_on, masked, vect, pin_low;
    logic awready, wready, bvalid, arready, rvalid, cpu_clk_en_ff, cpu_reset_ff, irq_vectored, ext_reset_n;
    logic vector_go_ff, resume_go_ff, reset_vector_go_ff;
    logic [7:0] awaddr, araddr, irq_flag, irq_mask, port_out_ff;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    halt_pkg::periph_run_t periph_run_ff;
    int err_count, checks_done, n;
    typedef struct {logic [4:0] ctrl; logic vect; logic [7:0] port;} row_t;
    // both clock sources, both watchdog options, each low-speed timer choice
    row_t rows [6] = '{'{5'h00, 1'h0, 8'ha5}, '{5'h02, 1'h1, 8'h3c}, '{5'h01, 1'h0, 8'hff},
                       '{5'h17, 1'h1, 8'h00}, '{5'h09, 1'h0, 8'h81}, '{5'h11, 1'h1, 8'h5a}};

    halt_standby_control u_halt_standby_control (.mclk(mclk), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .halt_exec(halt_exec),
        .cpu_clk_en_ff(cpu_clk_en_ff), .cpu_reset_ff(cpu_reset_ff), .vector_go_ff(vector_go_ff),
        .resume_go_ff(resume_go_ff), .reset_vector_go_ff(reset_vector_go_ff), .irq_flag(irq_flag),
        .irq_mask(irq_mask), .irq_vectored(irq_vectored), .ext_reset_n(ext_reset_n),
        .port_out_ff(port_out_ff), .periph_run_ff(periph_run_ff));
    irq_model u_irq_model (.req_on(req_on), .masked(masked), .vect(vect), .pin_low(pin_low),
        .irq_flag(irq_flag), .irq_mask(irq_mask), .irq_vectored(irq_vectored), .ext_reset_n(ext_reset_n));

    // 50 mhz clock
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // bready and rready stay high, so the answer is taken at the edge it is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int t;
        t = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (t == 0) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                rs = bresp;
                t = 1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int t;
        t = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        while (t == 0) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                v = rdata;
                rs = rresp;
                t = 1;
            end
        end
    endtask

    task automatic enter_halt;
        @(posedge mclk);
        halt_exec <= 1'h1;
        @(posedge mclk);
        halt_exec <= 1'h0;
        #1;
    endtask

    // counts edges from the request edge to the go pulse; clock must stay gated meanwhile
    task automatic await_go(input logic vg, input int exp_n);
        int k;
        logic go;
        k = 0;
        go = 1'h0;
        while (!go && k < 40) begin
            @(posedge mclk);
            halt_exec <= 1'h0;
            k++;
            #1;
            go = vg ? vector_go_ff : resume_go_ff;
            if (!go) chk(cpu_clk_en_ff, 32'h0);
        end
        chk(k, exp_n);
        chk(vg ? resume_go_ff : vector_go_ff, 32'h0);
        chk(cpu_clk_en_ff, 32'h1);
        @(posedge mclk);
        req_on <= 1'h0;
    endtask

    function automatic logic [8:0] exp_run(input logic [4:0] c);
        logic hs;
        hs = ~c[0];
        return {~c[1], hs, hs | (c[4] & c[2]), hs, hs, hs | c[3], hs | c[2], hs, hs};
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        complete_run;
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {reset, bready, rready, wstrb} = 7'h7f;
        {awvalid, wvalid, arvalid, halt_exec, req_on, masked, vect, pin_low} = 8'h00;
        {awaddr, araddr, wdata, err_count, checks_done} = '0;
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        rd(halt_pkg::CTRL_OFFSET, d, r);
        chk(d, 32'h0);
        chk(periph_run_ff, 32'h1ff);
        chk(port_out_ff, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(halt_pkg::CTRL_OFFSET, {27'h0, rows[i].ctrl}, r);
            wr(halt_pkg::PORT_OFFSET, {24'h0, rows[i].port}, r);
            vect <= rows[i].vect;
            enter_halt;
            chk(cpu_clk_en_ff, 32'h0);
            chk(periph_run_ff, exp_run(rows[i].ctrl));
            wr(halt_pkg::PORT_OFFSET, {24'h0, ~rows[i].port}, r);
            chk(port_out_ff, rows[i].port);
            req_on <= 1'h1;
            masked <= 1'h1;
            repeat (4) @(posedge mclk);
            #1;
            chk(cpu_clk_en_ff, 32'h0);
            @(posedge mclk);
            masked <= 1'h0;
            await_go(rows[i].vect, rows[i].vect ? 9 : 3);
            $display("test %0d done", i);
        end
        // request already pending when halt executes
        @(posedge mclk);
        req_on <= 1'h1;
        vect <= 1'h1;
        @(posedge mclk);
        halt_exec <= 1'h1;
        await_go(1'h1, 9);
        $display("pending test done");
        // reset pin during halt
        enter_halt;
        rd(halt_pkg::STATUS_OFFSET, d, r);
        chk(d[0], 32'h1);
        pin_low <= 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        chk({cpu_reset_ff, cpu_clk_en_ff}, 32'h3);
        @(posedge mclk);
        pin_low <= 1'h0;
        n = 0;
        repeat (3) begin
            @(posedge mclk);
            #1;
            if (reset_vector_go_ff === 1'h1) n++;
        end
        chk(n, 1);
        chk(cpu_reset_ff, 32'h0);
        // software-timed oscillator wait after the pin reset, one cycle per no-operation
        repeat (85) @(posedge mclk);
        rd(halt_pkg::STATUS_OFFSET, d, r);
        chk(d[0], 32'h0);
        wr(8'h10, 32'h1, r);
        chk(r, halt_pkg::RESP_SLVERR);
        rd(8'h10, d, r);
        chk(d, 32'h0);
        chk(r, halt_pkg::RESP_SLVERR);
        $display("reset pin and bus test done");
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
